// >>> rtl/mcl_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module mcl_ctl #(
	parameter int WAIT_CYC = mcl_pkg::REPLY_WAIT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	mcl_link_if.ctl link,
	input wire logic req_valid,
	input wire logic req_rw,
	input wire logic [5:0] req_addr,
	input wire logic [29:0] req_data,
	output logic req_ready,
	output logic rsp_valid,
	output logic [29:0] rsp_data,
	output logic rsp_err
);

	typedef enum {H_IDLE, H_SEND, H_WAIT, H_GAP} mcl_host_e;

	mcl_host_e h_q;
	logic [15:0] tmr_q;
	logic [5:0] tidx_q;
	logic thalf_q;
	logic [38:0] tsr_q;
	logic [2:0] tcrc_q;
	logic rw_q;
	logic vcc_q;
	logic ready_q;
	logic rsp_valid_q;
	logic [29:0] rsp_data_q;
	logic rsp_err_q;
	logic [5:0] tlen;
	logic tx_bit;
	logic half_end;
	logic os1_q, os2_q, os3_q;
	logic line_edge;
	logic [mcl_pkg::TMR_W-1:0] cnt_q, half_q;
	mcl_pkg::mcl_rx_e rx_q;
	logic bnd_q;
	logic [5:0] nbits_q;
	logic [34:0] sr_q;
	logic [2:0] crc_q;
	logic rx_done;

	assign link.vcc_mod = vcc_q;
	assign req_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign rsp_err = rsp_err_q;

	assign tlen = rw_q ? 6'h09 : 6'h27;
	assign tx_bit = (tidx_q < tlen) ? tsr_q[38] : tcrc_q[2];
	assign half_end = tmr_q == 16'(mcl_pkg::HOST_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// command sender
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			h_q <= H_IDLE;
			tmr_q <= '0;
			tidx_q <= '0;
			thalf_q <= 1'b0;
			tsr_q <= '0;
			tcrc_q <= '0;
			rw_q <= 1'b0;
			ready_q <= 1'b1;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= '0;
			rsp_err_q <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			unique case (h_q)
				H_IDLE: begin
					if (req_valid && ready_q) begin
						ready_q <= 1'b0;
						rw_q <= req_rw;
						tsr_q <= {mcl_pkg::SYNC_VAL, req_rw, req_addr, req_data};
						tcrc_q <= mcl_pkg::CRC_SEED;
						tidx_q <= '0;
						thalf_q <= 1'b0;
						tmr_q <= '0;
						h_q <= H_SEND;
					end
				end
				H_SEND: begin
					if (half_end) begin
						tmr_q <= '0;
						thalf_q <= ~thalf_q;
						if (thalf_q) begin
							if (tidx_q < tlen) begin
								tcrc_q <= mcl_pkg::crc_step(tcrc_q, tsr_q[38]);
								tsr_q <= {tsr_q[37:0], 1'b0};
							end else begin
								tcrc_q <= {tcrc_q[1:0], 1'b0};
							end
							tidx_q <= tidx_q + 6'h1;
							if (tidx_q == tlen + 6'h2) begin
								h_q <= rw_q ? H_WAIT : H_GAP;
							end
						end
					end else begin
						tmr_q <= tmr_q + 16'h1;
					end
				end
				H_WAIT: begin
					tmr_q <= tmr_q + 16'h1;
					if (rx_done) begin
						rsp_valid_q <= 1'b1;
						rsp_data_q <= sr_q[32:3];
						rsp_err_q <= (crc_q != 3'h0) || (sr_q[34:33] != mcl_pkg::SYNC_VAL);
						tmr_q <= '0;
						h_q <= H_GAP;
					end else if (tmr_q == 16'(WAIT_CYC - 1)) begin
						rsp_valid_q <= 1'b1;
						rsp_data_q <= '0;
						rsp_err_q <= 1'b1;
						tmr_q <= '0;
						h_q <= H_GAP;
					end
				end
				H_GAP: begin
					if (tmr_q == 16'(mcl_pkg::GAP_CYC - 1)) begin
						tmr_q <= '0;
						ready_q <= 1'b1;
						h_q <= H_IDLE;
					end else begin
						tmr_q <= tmr_q + 16'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			vcc_q <= 1'b0;
		end else begin
			vcc_q <= (h_q == H_SEND) ? mcl_pkg::manch_level(tx_bit, thalf_q) : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// reply receiver
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			os1_q <= 1'b0;
			os2_q <= 1'b0;
			os3_q <= 1'b0;
		end else begin
			os1_q <= link.out_level;
			os2_q <= os1_q;
			os3_q <= os2_q;
		end
	end

	assign line_edge = os2_q ^ os3_q;
	assign rx_done = (rx_q == mcl_pkg::RX_BITS) && (nbits_q == mcl_pkg::REPLY_BITS);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (line_edge) begin
			cnt_q <= '0;
		end else if (cnt_q != {mcl_pkg::TMR_W{1'b1}}) begin
			cnt_q <= cnt_q + mcl_pkg::TMR_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rx_q <= mcl_pkg::RX_IDLE;
			half_q <= '0;
			bnd_q <= 1'b0;
			nbits_q <= '0;
			sr_q <= '0;
			crc_q <= '0;
		end else if (h_q != H_WAIT || rx_done) begin
			rx_q <= mcl_pkg::RX_IDLE;
		end else begin
			unique case (rx_q)
				mcl_pkg::RX_IDLE: begin
					if (line_edge && os2_q) begin
						nbits_q <= 6'h1;
						sr_q <= '0;
						crc_q <= mcl_pkg::crc_step(mcl_pkg::CRC_SEED, 1'b0);
						rx_q <= mcl_pkg::RX_HALF;
					end
				end
				mcl_pkg::RX_HALF: begin
					if (line_edge) begin
						half_q <= cnt_q;
						bnd_q <= 1'b1;
						rx_q <= mcl_pkg::RX_BITS;
					end else if (cnt_q == {mcl_pkg::TMR_W{1'b1}}) begin
						rx_q <= mcl_pkg::RX_IDLE;
					end
				end
				mcl_pkg::RX_BITS: begin
					if (line_edge) begin
						if (mcl_pkg::is_mid_edge(cnt_q, half_q, bnd_q)) begin
							sr_q <= {sr_q[33:0], os3_q};
							crc_q <= mcl_pkg::crc_step(crc_q, os3_q);
							nbits_q <= nbits_q + 6'h1;
							bnd_q <= 1'b0;
						end else begin
							bnd_q <= 1'b1;
						end
					end else if (mcl_pkg::frame_timeout(cnt_q, half_q)) begin
						rx_q <= mcl_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> rtl/mcl_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - falling mid-cell is one, rising zero
// - frame opens with two zero sync bits
// - direction bit: zero write, one read
// - six-bit address follows direction bit
// - data length follows command type
// - three-bit crc closes frame, checked
// - read latches address, fetches word
// - reply on output pin after read
// - reply: sync, 30 bits msb first, crc
// - ecc on: six msbs are check bits
// - controller commands only via supply pin
// - access code must match stored code
// - access code within 70 ms, first; code also accepts it after other frames
// - one access code per power cycle
// - msb zero nonvolatile; 100100 is 0x24
// - access code is write to 0x24
// - write stores data at address
// - decoder follows 4 to 100 kbps
// - output held low 45 us before reply
// - reply starts 25 to 150 us later
// - disable floats output until enable; read replies still drive the pin
module mcl_dev #(
	parameter int ACC_CYC = mcl_pkg::ACC_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	mcl_link_if.dev link,
	input wire logic ecc_check_en,
	input wire logic norm_out,
	output logic access_granted,
	output logic out_enabled
);

	typedef enum {TX_NORM, TX_LOW, TX_SEND, TX_REL} mcl_tx_e;

	function automatic logic [5:0] ecc_bits(input logic [23:0] d);
		logic [5:0] e;
		e = '0;
		for (int i = 0; i < 24; i++) begin
			e[i % 6] = e[i % 6] ^ d[i];
		end
		return e;
	endfunction

	logic vs1_q, vs2_q, vs3_q;
	logic line_edge;
	logic [mcl_pkg::TMR_W-1:0] cnt_q, half_q;
	mcl_pkg::mcl_rx_e rx_q;
	logic bnd_q;
	logic [5:0] nbits_q;
	logic [41:0] sr_q;
	logic [2:0] crc_q;
	logic rw_q;
	logic frame_done;
	logic sync_ok;
	logic frame_good;
	logic [5:0] frame_addr;
	logic [29:0] frame_data;
	logic is_code;
	logic [31:0] acc_cnt_q;
	logic unlocked_q;
	logic cmd_ok;
	logic [29:0] mem_q [0:63];
	logic [29:0] mem_word;
	logic out_en_q;
	mcl_tx_e tx_q;
	logic [11:0] ttmr_q;
	logic [5:0] tidx_q;
	logic thalf_q;
	logic [31:0] tsr_q;
	logic [2:0] tcrc_q;
	logic tx_bit;
	logic out_d_q, out_oe_q;

	assign link.out_d = out_d_q;
	assign link.out_oe = out_oe_q;
	assign access_granted = unlocked_q;
	assign out_enabled = out_en_q;

	// ----------------------------------------------------------------
	// supply line decoder
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			vs1_q <= 1'b0;
			vs2_q <= 1'b0;
			vs3_q <= 1'b0;
		end else begin
			vs1_q <= link.vcc_mod;
			vs2_q <= vs1_q;
			vs3_q <= vs2_q;
		end
	end

	assign line_edge = vs2_q ^ vs3_q;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (line_edge) begin
			cnt_q <= '0;
		end else if (cnt_q != {mcl_pkg::TMR_W{1'b1}}) begin
			cnt_q <= cnt_q + mcl_pkg::TMR_W'(1);
		end
	end

	assign frame_done = (rx_q == mcl_pkg::RX_BITS) &&
		((nbits_q == mcl_pkg::READ_BITS && rw_q == mcl_pkg::RW_READ) ||
		(nbits_q == mcl_pkg::WRITE_BITS && rw_q == mcl_pkg::RW_WRITE));

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rx_q <= mcl_pkg::RX_IDLE;
			half_q <= '0;
			bnd_q <= 1'b0;
			nbits_q <= '0;
			sr_q <= '0;
			crc_q <= '0;
			rw_q <= 1'b0;
		end else begin
			unique case (rx_q)
				mcl_pkg::RX_IDLE: begin
					if (line_edge && vs2_q) begin
						nbits_q <= 6'h1;
						sr_q <= '0;
						crc_q <= mcl_pkg::crc_step(mcl_pkg::CRC_SEED, 1'b0);
						rx_q <= mcl_pkg::RX_HALF;
					end
				end
				mcl_pkg::RX_HALF: begin
					if (line_edge) begin
						half_q <= cnt_q;
						bnd_q <= 1'b1;
						rx_q <= mcl_pkg::RX_BITS;
					end else if (cnt_q == {mcl_pkg::TMR_W{1'b1}}) begin
						rx_q <= mcl_pkg::RX_IDLE;
					end
				end
				mcl_pkg::RX_BITS: begin
					if (frame_done) begin
						rx_q <= mcl_pkg::RX_IDLE;
					end else if (line_edge) begin
						// bit is level before mid edge
						if (mcl_pkg::is_mid_edge(cnt_q, half_q, bnd_q)) begin
							sr_q <= {sr_q[40:0], vs3_q};
							crc_q <= mcl_pkg::crc_step(crc_q, vs3_q);
							nbits_q <= nbits_q + 6'h1;
							bnd_q <= 1'b0;
							if (nbits_q == 6'h2) begin
								rw_q <= vs3_q;
							end
						end else begin
							bnd_q <= 1'b1;
						end
					end else if (mcl_pkg::frame_timeout(cnt_q, half_q)) begin
						rx_q <= mcl_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// frame fields and checks
	// ----------------------------------------------------------------
	// address after direction bit
	assign frame_addr = rw_q ? sr_q[8:3] : sr_q[38:33];
	assign frame_data = sr_q[32:3];
	assign sync_ok = rw_q ? (sr_q[11:10] == mcl_pkg::SYNC_VAL) :
		(sr_q[41:40] == mcl_pkg::SYNC_VAL);
	// running crc over frame ends at zero
	assign frame_good = frame_done && sync_ok && (crc_q == 3'h0);
	// code is write to volatile 0x24
	assign is_code = (rw_q == mcl_pkg::RW_WRITE) && (frame_addr == mcl_pkg::VOL_ADDR) &&
		(frame_data == mcl_pkg::ACCESS_CODE);
	assign cmd_ok = frame_good && unlocked_q;

	// ----------------------------------------------------------------
	// access gate
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			acc_cnt_q <= '0;
		end else if (acc_cnt_q < 32'(ACC_CYC)) begin
			acc_cnt_q <= acc_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			unlocked_q <= 1'b0;
		end else if (frame_good && is_code && acc_cnt_q < 32'(ACC_CYC)) begin
			unlocked_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// storage and output control
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 64; i++) begin
				mem_q[i] <= '0;
			end
		end else if (cmd_ok && rw_q == mcl_pkg::RW_WRITE && frame_addr != mcl_pkg::VOL_ADDR) begin
			mem_q[frame_addr] <= frame_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out_en_q <= 1'b1;
		end else if (cmd_ok && rw_q == mcl_pkg::RW_WRITE && frame_addr == mcl_pkg::VOL_ADDR) begin
			if (frame_data == mcl_pkg::DATA_DIS_OUT) begin
				out_en_q <= 1'b0;
			end else if (frame_data == mcl_pkg::DATA_EN_OUT) begin
				out_en_q <= 1'b1;
			end
		end
	end

	assign mem_word = ecc_check_en ? {ecc_bits(mem_q[frame_addr][23:0]),
		mem_q[frame_addr][23:0]} : mem_q[frame_addr];

	// ----------------------------------------------------------------
	// read reply sender
	// ----------------------------------------------------------------
	assign tx_bit = (tidx_q < mcl_pkg::REPLY_PAYLOAD) ? tsr_q[31] : tcrc_q[2];

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tx_q <= TX_NORM;
			ttmr_q <= '0;
			tidx_q <= '0;
			thalf_q <= 1'b0;
			tsr_q <= '0;
			tcrc_q <= '0;
		end else begin
			unique case (tx_q)
				TX_NORM: begin
					if (cmd_ok && rw_q == mcl_pkg::RW_READ) begin
						tsr_q <= {mcl_pkg::SYNC_VAL, mem_word};
						ttmr_q <= '0;
						tx_q <= TX_LOW;
					end
				end
				TX_LOW: begin
					if (ttmr_q == 12'(mcl_pkg::ROUT_LOW_CYC - 1)) begin
						ttmr_q <= '0;
						tidx_q <= '0;
						thalf_q <= 1'b0;
						tcrc_q <= mcl_pkg::CRC_SEED;
						tx_q <= TX_SEND;
					end else begin
						ttmr_q <= ttmr_q + 12'h1;
					end
				end
				TX_SEND: begin
					if (ttmr_q == 12'(mcl_pkg::REPLY_HALF_CYC - 1)) begin
						ttmr_q <= '0;
						thalf_q <= ~thalf_q;
						if (thalf_q) begin
							if (tidx_q < mcl_pkg::REPLY_PAYLOAD) begin
								tcrc_q <= mcl_pkg::crc_step(tcrc_q, tsr_q[31]);
								tsr_q <= {tsr_q[30:0], 1'b0};
							end else begin
								tcrc_q <= {tcrc_q[1:0], 1'b0};
							end
							tidx_q <= tidx_q + 6'h1;
							if (tidx_q == mcl_pkg::REPLY_BITS - 6'h1) begin
								tx_q <= TX_REL;
							end
						end
					end else begin
						ttmr_q <= ttmr_q + 12'h1;
					end
				end
				TX_REL: begin
					if (ttmr_q == 12'(mcl_pkg::ROUT_EN_CYC - 1)) begin
						ttmr_q <= '0;
						tx_q <= TX_NORM;
					end else begin
						ttmr_q <= ttmr_q + 12'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out_d_q <= 1'b0;
			out_oe_q <= 1'b0;
		end else begin
			unique case (tx_q)
				TX_NORM: begin
					out_d_q <= norm_out;
					out_oe_q <= out_en_q;
				end
				TX_SEND: begin
					out_d_q <= mcl_pkg::manch_level(tx_bit, thalf_q);
					out_oe_q <= 1'b1;
				end
				TX_LOW, TX_REL: begin
					out_d_q <= 1'b0;
					out_oe_q <= 1'b1;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> rtl/mcl_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mcl_link_if;
	logic vcc_mod;
	logic out_d;
	logic out_oe;
	logic out_level;

	// released output pin is pulled low
	assign out_level = out_oe & out_d;

	modport dev (input vcc_mod, output out_d, output out_oe);
	modport ctl (output vcc_mod, input out_level);
endinterface
`default_nettype wire

// >>> rtl/mcl_pkg.sv
`default_nettype none
package mcl_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int ACC_TIMEOUT_MS = 70;
	localparam int ACC_TIMEOUT_CYC = ACC_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int ROUT_LOW_US = 45;
	localparam int ROUT_LOW_CYC = ROUT_LOW_US * (CLK_HZ / 1_000_000);
	localparam int ROUT_EN_US = 45;
	localparam int ROUT_EN_CYC = ROUT_EN_US * (CLK_HZ / 1_000_000);
	localparam int REPLY_BIT_NS = 10_000;
	localparam int REPLY_HALF_CYC = REPLY_BIT_NS / 2 / CLK_PERIOD_NS;
	localparam int HOST_BIT_NS = 10_000;
	localparam int HOST_HALF_CYC = HOST_BIT_NS / 2 / CLK_PERIOD_NS;
	localparam int GAP_CYC = 4 * HOST_HALF_CYC;
	localparam int REPLY_WAIT_US = 1000;
	localparam int REPLY_WAIT_CYC = REPLY_WAIT_US * (CLK_HZ / 1_000_000);
	localparam int TMR_W = 17;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam logic [1:0] SYNC_VAL = 2'h0;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam logic [5:0] VOL_ADDR = 6'h24;
	localparam logic [29:0] ACCESS_CODE = 30'h2781_1F77;
	localparam logic [29:0] DATA_DIS_OUT = 30'h0000_0010;
	localparam logic [29:0] DATA_EN_OUT = 30'h0000_0000;
	localparam logic [5:0] READ_BITS = 6'h0C;
	localparam logic [5:0] WRITE_BITS = 6'h2A;
	localparam logic [5:0] REPLY_BITS = 6'h23;
	localparam logic [5:0] REPLY_PAYLOAD = 6'h20;
	localparam logic [2:0] CRC_POLY = 3'h3;
	localparam logic [2:0] CRC_SEED = 3'h7;

	typedef enum {RX_IDLE, RX_HALF, RX_BITS} mcl_rx_e;

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
		logic fb;
		fb = c[2] ^ b;
		crc_step = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
	endfunction

	// edge more than 1.5 half-bits after a mid edge, or any edge after a boundary
	function automatic logic is_mid_edge(input logic [TMR_W-1:0] cnt,
		input logic [TMR_W-1:0] half, input logic after_bnd);
		is_mid_edge = after_bnd || ({1'b0, cnt, 1'b0} > ({2'b0, half} + {1'b0, half, 1'b0}));
	endfunction

	function automatic logic frame_timeout(input logic [TMR_W-1:0] cnt,
		input logic [TMR_W-1:0] half);
		frame_timeout = ({2'b0, cnt} > {half, 2'b0}) || (cnt == {TMR_W{1'b1}});
	endfunction

	// one first half, zero second half for a one
	function automatic logic manch_level(input logic b, input logic second_half);
		manch_level = second_half ? ~b : b;
	endfunction

endpackage
`default_nettype wire

// >>> test/mcl_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mcl_link_assertions (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic vcc_mod,
	input wire logic out_oe,
	input wire logic req_valid,
	input wire logic req_rw,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [29:0] rsp_data,
	input wire logic access_granted,
	input wire logic out_enabled
);
	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	logic prev_q;
	logic wr_q;
	logic [9:0] run_q;
	logic [15:0] busy_q;

	// run length of the command line, saturating
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prev_q <= 1'h0;
			run_q <= 10'h3FF;
		end else begin
			prev_q <= vcc_mod;
			if (vcc_mod != prev_q) begin
				run_q <= 10'h000;
			end else if (run_q != 10'h3FF) begin
				run_q <= run_q + 10'h001;
			end
		end
	end

	// cycles since the controller took a request
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busy_q <= 16'h0000;
			wr_q <= 1'h0;
		end else if (req_valid && req_ready) begin
			busy_q <= 16'h0000;
			wr_q <= !req_rw;
		end else if (!req_ready) begin
			busy_q <= busy_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	sequence take_s;
		req_valid && req_ready;
	endsequence
	sequence sync_low_s;
		(!vcc_mod) [*8];
	endsequence
	sequence sync_rise_s;
		$rose(vcc_mod);
	endsequence

	sync_start_a:
		assert property (take_s |=> sync_low_s ##[236:246] sync_rise_s) else $error("sync start");
	half_bit_a:
		assert property ((vcc_mod != prev_q) && run_q < 10'h258 |-> run_q inside {10'h0F9, 10'h1F3})
		else $error("half bit length");
	idle_line_a:
		assert property (req_ready |-> !vcc_mod) else $error("line not idle");
	write_len_a:
		assert property ($rose(req_ready) && wr_q |-> busy_q inside {[16'h55E6:16'h55FA]})
		else $error("write frame length");
	grant_sticky_a:
		assert property (access_granted |=> access_granted) else $error("grant lost");
	grant_write_a:
		assert property ($rose(access_granted) |-> !req_ready && wr_q) else $error("grant cause");
	rsp_pulse_a:
		assert property (rsp_valid |=> !rsp_valid) else $error("response pulse");
	rsp_busy_a:
		assert property (rsp_valid |-> !req_ready) else $error("response outside read");
	err_data_a:
		assert property (rsp_valid && rsp_err |-> rsp_data == 30'h0000_0000) else $error("error data");
	float_out_a:
		assert property ($fell(out_enabled) |-> ##[0:4] !out_oe ##1 (!out_oe) [*8])
		else $error("pin not released");
endmodule
`default_nettype wire

// >>> test/tb_manchester_programming_command_link.sv
`timescale 1ns/10ps
`default_nettype none
module tb_manchester_programming_command_link;
	logic core_clk = 1'h0;
	logic rst_b = 1'h0;
	logic ecc_check_en = 1'h0;
	logic norm_out = 1'h0;
	logic req_valid = 1'h0;
	logic req_rw = 1'h0;
	logic [5:0] req_addr = 6'h00;
	logic [29:0] req_data = 30'h0000_0000;
	logic req_ready;
	logic rsp_valid;
	logic rsp_err;
	logic access_granted;
	logic out_enabled;
	logic [29:0] rsp_data;
	logic [30:0] exp_q[$];
	logic [31:0] rng_q = 32'h0000_0037;
	logic [29:0] wdata;
	logic [5:0] waddr;
	int err_total = 0;
	int cmp_count = 0;

	mcl_link_if link_i ();
	mcl_dev #(.ACC_CYC(100000)) mcl_dev_i (.core_clk(core_clk), .rst_b(rst_b), .link(link_i),
		.ecc_check_en(ecc_check_en), .norm_out(norm_out), .access_granted(access_granted),
		.out_enabled(out_enabled));
	mcl_ctl #(.WAIT_CYC(25000)) mcl_ctl_i (.core_clk(core_clk), .rst_b(rst_b), .link(link_i),
		.req_valid(req_valid), .req_rw(req_rw), .req_addr(req_addr), .req_data(req_data),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
	mcl_link_assertions mcl_link_assertions_i (.core_clk(core_clk), .rst_b(rst_b),
		.vcc_mod(link_i.vcc_mod), .out_oe(link_i.out_oe), .req_valid(req_valid),
		.req_rw(req_rw), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
		.rsp_data(rsp_data), .access_granted(access_granted), .out_enabled(out_enabled));

	always #10 core_clk = ~core_clk;
	always @(negedge core_clk) norm_out <= ~norm_out;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic logic [29:0] with_chk(input logic [29:0] d);
		logic [5:0] c;
		c = 6'h00;
		for (int j = 0; j < 24; j++) c[j % 6] = c[j % 6] ^ d[j];
		return {c, d[23:0]};
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one request, with the line watched half by half
	task automatic send(input logic rw, input logic [5:0] addr, input logic [29:0] data);
		logic bits[$];
		logic [2:0] c;
		logic [127:0] seen;
		logic [127:0] want;
		int n;
		bits = {1'h0, 1'h0, rw};
		for (int i = 5; i >= 0; i--) bits.push_back(addr[i]);
		if (rw == mcl_pkg::RW_WRITE) for (int i = 29; i >= 0; i--) bits.push_back(data[i]);
		c = mcl_pkg::CRC_SEED;
		foreach (bits[i]) c = {c[1:0], 1'h0} ^ ((c[2] ^ bits[i]) ? mcl_pkg::CRC_POLY : 3'h0);
		for (int i = 2; i >= 0; i--) bits.push_back(c[i]);
		seen = 128'h0;
		want = 128'h0;
		req_rw = rw;
		req_addr = addr;
		req_data = data;
		req_valid = 1'h1;
		while (req_ready !== 1'h1) @(negedge core_clk);
		@(negedge core_clk);
		req_valid = 1'h0;
		foreach (bits[i]) begin
			repeat ((i == 0) ? 125 : 250) @(negedge core_clk);
			seen = {seen[126:0], link_i.vcc_mod};
			repeat (250) @(negedge core_clk);
			seen = {seen[126:0], link_i.vcc_mod};
			want = {want[125:0], bits[i], ~bits[i]};
		end
		check(seen, want);
		n = 0;
		while (req_ready !== 1'h1 && n < 60000) begin
			@(negedge core_clk);
			n++;
		end
		check(128'(n < 60000), 128'h1);
	endtask

	// ----------------------------------------------------------------
	// response watcher
	// ----------------------------------------------------------------
	always @(negedge core_clk) begin
		if (rst_b === 1'h1 && rsp_valid === 1'h1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("[ERR] %0t response with none expected", $time);
			end else begin
				check(128'({rsp_err, rsp_data}), 128'(exp_q.pop_front()));
			end
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(negedge core_clk);
		rst_b = 1'h1;
		@(negedge core_clk);
		send(mcl_pkg::RW_WRITE, mcl_pkg::VOL_ADDR, mcl_pkg::ACCESS_CODE ^ 30'h0000_0001);
		check(128'(access_granted), 128'h0);
		send(mcl_pkg::RW_WRITE, mcl_pkg::VOL_ADDR, mcl_pkg::ACCESS_CODE);
		check(128'(access_granted), 128'h1);
		rng_q = xs(rng_q);
		waddr = {1'h0, rng_q[4:0]};
		rng_q = xs(rng_q);
		wdata = rng_q[31:2];
		send(mcl_pkg::RW_WRITE, waddr, wdata);
		ecc_check_en = 1'h1;
		exp_q.push_back({1'h0, with_chk(wdata)});
		send(mcl_pkg::RW_READ, waddr, 30'h0000_0000);
		check(128'(exp_q.size()), 128'h0);
		send(mcl_pkg::RW_WRITE, mcl_pkg::VOL_ADDR, mcl_pkg::DATA_DIS_OUT);
		check(128'({out_enabled, link_i.out_oe, link_i.out_level}), 128'h0);
		end_sim();
	end

	initial begin
		repeat (130000) @(negedge core_clk);
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire
